/* File: design/lei_consts.vh */
// Constants for the receive error interrupt enable block.
// Assumes an AXI4-Lite register bus with 32-bit data and byte addressing.
`ifndef LEI_CONSTS_VH
`define LEI_CONSTS_VH

// Register byte offsets.
`define LEI_OFF_EN_SET      8'h00
`define LEI_OFF_EN_CLR      8'h04
`define LEI_OFF_CTRL        8'h08
`define LEI_OFF_IRQ_STAT    8'h0C
`define LEI_OFF_IRQ_MASK    8'h10
`define LEI_OFF_ERR_FLAGS   8'h14

// Enable field: bit 28 sync mismatch, 27 no response, 26 framing, 25 overrun, 24 parity.
`define LEI_EN_MSB          28
`define LEI_EN_LSB          24
`define LEI_SYNC_BIT        4
`define LEI_NORESP_BIT      3
`define LEI_NERR            5

// Control register fields.
`define LEI_CTRL_LIN_BIT    0
`define LEI_CTRL_PROT_BIT   1

// Reset values.
`define LEI_EN_RST          5'h00
`define LEI_MASK_RST        5'h00
`define LEI_CTRL_RST        2'h0

// Enables that only LIN mode may write or use.
`define LEI_LIN_ONLY_MASK   5'h18

// AXI responses.
`define LEI_RESP_OKAY       2'h0
`define LEI_RESP_SLVERR     2'h2

`endif

/* File: design/lei_top.v */
// Receive error interrupt enables with an AXI4-Lite register slave.
// Assumes error flags arrive as levels synchronous to aclk from the error
// detectors, and that one write and one read at most are outstanding.
`timescale 1ns/1ps
`include "lei_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// (RULE1) Sync-field mismatch error raises a request when bit 28 enable is set.
// (RULE2) No-response error raises a request when bit 27 enable is set.
// (RULE3) Framing error raises a request when bit 26 enable is set.
// (RULE4) Overrun error raises a request when bit 25 enable is set.
// (RULE5) Parity error raises a request when bit 24 enable is set.
// (RULE6) Sync-field and no-response enables act only in LIN mode.
// (RULE7) Framing, overrun and parity enables act in both modes.
// (RULE8) Reading an enable bit returns one when enabled, zero otherwise.
// (RULE9) Writing one sets an enable; writing zero leaves it unchanged.
// (RULE10) Bits 23 to 14 read as zero and writes there change nothing.
// (RULE11) LIN-only enables write only in LIN mode; all enables reset to zero.
// (RULE12) Each request is error flag AND enable, evaluated every clock.
module lei_top #(
    parameter ADDR_W = 8
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire [4:0]        err_flag,
    output reg  [4:0]        err_irq_req,
    output reg               lin_mode,
    output reg               irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Register indices returned by reg_index.
    localparam [2:0] IDX_EN_SET = 3'h0;
    localparam [2:0] IDX_EN_CLR = 3'h1;
    localparam [2:0] IDX_CTRL   = 3'h2;
    localparam [2:0] IDX_STAT   = 3'h3;
    localparam [2:0] IDX_MASK   = 3'h4;
    localparam [2:0] IDX_FLAGS  = 3'h5;
    localparam [2:0] IDX_NONE   = 3'h7;

    // Register index for a byte address; 3'h7 marks an unmapped address.
    function [2:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            case (addr)
                `LEI_OFF_EN_SET:    reg_index = IDX_EN_SET;
                `LEI_OFF_EN_CLR:    reg_index = IDX_EN_CLR;
                `LEI_OFF_CTRL:      reg_index = IDX_CTRL;
                `LEI_OFF_IRQ_STAT:  reg_index = IDX_STAT;
                `LEI_OFF_IRQ_MASK:  reg_index = IDX_MASK;
                `LEI_OFF_ERR_FLAGS: reg_index = IDX_FLAGS;
                default:            reg_index = IDX_NONE;
            endcase
        end
    endfunction

    // Places a five-bit error vector at bits 28 to 24; the rest read as zero.
    function [31:0] err_field;
        input [4:0] v;
        begin
            err_field = {3'h0, v, 24'h000000};
        end
    endfunction

    // Enable positions that may be written, and may request, in the given mode.
    function [4:0] mode_mask;
        input lin;
        begin
            mode_mask = lin ? 5'h1F : ~`LEI_LIN_ONLY_MASK;
        end
    endfunction

    // Refused accesses answer with a slave error and change no state.
    function [1:0] resp_code;
        input [2:0] idx;
        input       is_wr;
        begin
            if (idx == IDX_NONE || (is_wr && idx == IDX_FLAGS)) begin
                resp_code = `LEI_RESP_SLVERR;
            end else begin
                resp_code = `LEI_RESP_OKAY;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State.

    reg  [4:0]        en_r;
    reg  [4:0]        en_nxt;
    reg  [4:0]        stat_r;
    reg  [4:0]        stat_nxt;
    reg  [4:0]        mask_r;
    reg  [4:0]        mask_nxt;
    reg               prot_r;
    reg               prot_nxt;
    reg               lin_nxt;
    reg  [4:0]        req_nxt;

    reg               aw_full_r;
    reg  [ADDR_W-1:0] aw_addr_r;
    reg               w_full_r;
    reg  [31:0]       w_data_r;
    reg  [3:0]        w_strb_r;

    wire              wr_fire;
    wire [2:0]        wr_idx;
    wire [2:0]        rd_idx;
    wire [4:0]        wr_bits;
    wire [4:0]        lin_wr_mask;
    wire              wr_en_set;
    wire              wr_en_clr;
    wire              wr_ctrl;
    wire              wr_stat;
    wire              wr_mask;

    reg  [31:0]       rd_word;

    assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
    assign wr_idx  = reg_index(aw_addr_r);
    assign rd_idx  = reg_index(s_axi_araddr);

    // Enable and status bits all sit in the top byte, so lane 3 gates them.
    assign wr_bits = w_strb_r[3] ? w_data_r[`LEI_EN_MSB:`LEI_EN_LSB] : 5'h00;

    // Outside LIN mode the LIN-only positions are write protected.
    assign lin_wr_mask = mode_mask(lin_mode); // RULE11

    // One strobe per register, so each register process below stays small.
    assign wr_en_set = wr_fire && (wr_idx == IDX_EN_SET);
    assign wr_en_clr = wr_fire && (wr_idx == IDX_EN_CLR);
    assign wr_ctrl   = wr_fire && (wr_idx == IDX_CTRL) && w_strb_r[0];
    assign wr_stat   = wr_fire && (wr_idx == IDX_STAT);
    assign wr_mask   = wr_fire && (wr_idx == IDX_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the enable, control and interrupt registers.

    // Enable register: one sets through the set register, one clears through
    // the clear register, and LIN-only positions are frozen outside LIN mode.
    always @* begin
        en_nxt = en_r;
        if (wr_en_set) begin
            en_nxt = en_r | (wr_bits & lin_wr_mask); // RULE9 RULE10 RULE11
        end else if (wr_en_clr) begin
            en_nxt = en_r & ~(wr_bits & lin_wr_mask); // RULE11
        end
    end

    // Control register: mode select and the protected-write flag. The flag is
    // kept for software only; enables read back the same in either state.
    always @* begin
        lin_nxt  = lin_mode;
        prot_nxt = prot_r;
        if (wr_ctrl) begin
            lin_nxt  = w_data_r[`LEI_CTRL_LIN_BIT];
            prot_nxt = w_data_r[`LEI_CTRL_PROT_BIT];
        end
    end

    // Mask register: a set bit lets the matching status bit drive irq.
    always @* begin
        mask_nxt = mask_r;
        if (wr_mask) begin
            mask_nxt = wr_bits;
        end
    end

    // A LIN-only error never requests outside LIN mode, even if its enable
    // was left set when the mode changed.
    always @* begin
        req_nxt = err_flag & en_r; // RULE12 RULE1 RULE2 RULE3 RULE4 RULE5 RULE7
        req_nxt = req_nxt & mode_mask(lin_mode); // RULE6
    end

    // Set wins over a write-one-to-clear in the same cycle, so an error that
    // arrives while software clears its bit is never lost.
    always @* begin
        stat_nxt = stat_r;
        if (wr_stat) begin
            stat_nxt = stat_r & ~wr_bits;
        end
        stat_nxt = stat_nxt | req_nxt;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            en_r        <= `LEI_EN_RST; // RULE11
            mask_r      <= `LEI_MASK_RST;
            stat_r      <= 5'h00;
            prot_r      <= 1'b0;
            lin_mode    <= 1'b0;
        end else begin
            en_r        <= en_nxt;
            mask_r      <= mask_nxt;
            stat_r      <= stat_nxt;
            prot_r      <= prot_nxt;
            lin_mode    <= lin_nxt;
        end
    end

    // Both request outputs are registered so that every top-level output
    // comes from a flip-flop; they trail the error flags by one clock.
    always @(posedge aclk) begin
        if (!aresetn) begin
            err_irq_req <= 5'h00;
            irq         <= 1'b0;
        end else begin
            err_irq_req <= req_nxt; // RULE12
            irq         <= |(stat_nxt & mask_nxt);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels. Address and data are caught independently,
    // so the master may offer them in either order; the register update and
    // the response follow one cycle after both are held. Ready returns only
    // after the response is taken, which keeps one write in flight and the
    // captured payload stable.

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_full_r     <= 1'b0;
            aw_addr_r     <= {ADDR_W{1'b0}};
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (wr_fire) begin
                aw_full_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_full_r     <= 1'b0;
            w_data_r     <= 32'h00000000;
            w_strb_r     <= 4'h0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r     <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                w_full_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LEI_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= resp_code(wr_idx, 1'b1);
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channels.

    always @* begin
        rd_word = 32'h00000000;
        case (rd_idx)
            IDX_EN_SET: rd_word = err_field(en_r); // RULE8 RULE10
            IDX_EN_CLR: rd_word = err_field(en_r); // RULE8
            IDX_CTRL:   rd_word = {30'h0, prot_r, lin_mode};
            IDX_STAT:   rd_word = err_field(stat_r);
            IDX_MASK:   rd_word = err_field(mask_r);
            IDX_FLAGS:  rd_word = err_field(err_flag);
            default:    rd_word = 32'h00000000;
        endcase
    end

    // Read address channel: one read in flight, ready returns once data are taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Read data are captured with the address, so a later register change
    // cannot alter a word that is already on the bus.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `LEI_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= resp_code(rd_idx, 1'b0);
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* File: verif/lei_chk_asserts.sv */
// Checker for the receive error interrupt enable block, watching top ports only.
// Assumes one aclk domain and a synchronous active-low reset.
`timescale 1ns/1ps
module lei_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire [4:0]  err_flag,
    input wire [4:0]  err_irq_req,
    input wire        lin_mode
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sync_req_a: assert property (err_irq_req[4] |-> $past(err_flag[4]))
        else $error("sync request without flag");
    noresp_req_a: assert property (err_irq_req[3] |-> $past(err_flag[3]))
        else $error("no response request without flag");
    frame_req_a: assert property (err_irq_req[2] |-> $past(err_flag[2]))
        else $error("framing request without flag");
    ovr_req_a: assert property ($rose(err_irq_req[1]) |-> $past(err_flag[1]))
        else $error("overrun request without flag");
    par_req_a: assert property (!$past(err_flag[0]) |-> !err_irq_req[0])
        else $error("parity request without flag");
    lin_gate_a: assert property (!$past(lin_mode) |-> err_irq_req[4:3] == 2'b00)
        else $error("lin-only request outside lin mode");
    rsv_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[23:14] == 10'h000)
        else $error("reserved bits read nonzero");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    rst_clear_a: assert property (!$past(aresetn) |-> err_irq_req == 5'h00 && !lin_mode)
        else $error("state not cleared by reset");
endmodule

/* File: verif/lei_top_tb.sv */
// Self-checking bench for lei_top driven over AXI4-Lite.
// Assumes the byte map of lei_consts.vh and one outstanding access per direction.
`timescale 1ns/1ps
module lei_top_tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [4:0]  err_flag = 5'h00;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [4:0]  err_irq_req;
    wire         lin_mode, irq;
    integer      failures = 0, check_count = 0, i;
    lei_top #(.ADDR_W(8)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .err_flag, .err_irq_req, .lin_mode, .irq);
    initial begin
        forever #5 aclk = ~aclk;
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    // A bus wait that runs out ends the run rather than hanging it.
    task got_ok(input logic ok);
        begin
            if (ok !== 1'b1) begin
                failures = failures + 1;
                $display("ERROR %0t: bus timeout", $time);
                test_done;
            end
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        integer n;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                n = n + 1;
            end while (!s_axi_bvalid && n < 40);
            got_ok(s_axi_bvalid);
            s_axi_bready <= 1'b0;
            check({30'h0, s_axi_bresp}, {30'h0, er});
            // One idle edge, so a following call never reassigns a signal here.
            @(posedge aclk);
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        integer n;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                n = n + 1;
            end while (!s_axi_rvalid && n < 40);
            got_ok(s_axi_rvalid);
            s_axi_rready <= 1'b0;
            check(s_axi_rdata, ed);
            check({30'h0, s_axi_rresp}, {30'h0, er});
            @(posedge aclk);
        end
    endtask
    task flg(input logic [4:0] v, input logic [4:0] e);
        begin
            err_flag <= v;
            repeat (3) @(posedge aclk);
            check({27'h0, err_irq_req}, {27'h0, e});
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 32'h0, 2'h0);
        s_axi_wstrb <= 4'h7;
        wr(8'h00, 32'hFFFFFFFF, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd(8'h00, 32'h0, 2'h0);
        wr(8'h00, 32'hFFFFFFFF, 2'h0);
        rd(8'h00, 32'h07000000, 2'h0);
        wr(8'h00, 32'h0, 2'h0);
        rd(8'h00, 32'h07000000, 2'h0);
        flg(5'h1F, 5'h07);
        flg(5'h00, 5'h00);
        $display("sci mode test done");
        wr(8'h08, 32'h3, 2'h0);
        check({31'h0, lin_mode}, 32'h1);
        rd(8'h08, 32'h3, 2'h0);
        wr(8'h00, 32'h18000000, 2'h0);
        rd(8'h00, 32'h1F000000, 2'h0);
        for (i = 0; i < 5; i = i + 1) begin
            flg(5'h01 << i, 5'h01 << i);
        end
        flg(5'h00, 5'h00);
        $display("lin mode test done");
        wr(8'h0C, 32'h1F000000, 2'h0);
        rd(8'h0C, 32'h0, 2'h0);
        wr(8'h10, 32'h01000000, 2'h0);
        flg(5'h02, 5'h02);
        check({31'h0, irq}, 32'h0);
        flg(5'h01, 5'h01);
        check({31'h0, irq}, 32'h1);
        flg(5'h00, 5'h00);
        rd(8'h0C, 32'h03000000, 2'h0);
        wr(8'h0C, 32'h01000000, 2'h0);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        rd(8'h0C, 32'h02000000, 2'h0);
        $display("interrupt test done");
        wr(8'h08, 32'h0, 2'h0);
        check({31'h0, lin_mode}, 32'h0);
        flg(5'h1F, 5'h07);
        flg(5'h00, 5'h00);
        wr(8'h04, 32'h1F000000, 2'h0);
        rd(8'h00, 32'h18000000, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h14, 32'hFFFFFFFF, 2'h2);
        $display("mode and refusal test done");
        test_done;
    end
endmodule
bind lei_top lei_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .err_flag, .err_irq_req, .lin_mode);
